// ===== design/bst_pkg.sv
// Package for the boundary-scan test-port datapath.
// Assumes one hclk domain; the test-port pins arrive asynchronously.
package bst_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 8-bit register per word)
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_MCU_CONTROL       = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET_CAUSE       = 32'h0000_0004;
    localparam int          REG_W                  = 8;
    localparam int          BIT_TEST_PORT_DISABLE  = 7;
    localparam int          BIT_GLOBAL_PULLUP_DIS  = 4;
    localparam int          BIT_TEST_RESET_FLAG    = 4;
    localparam logic [7:0]  MCU_CONTROL_RST        = 8'h00;

    // ------------------------------------------------------------
    // Timed write window, in core cycles
    // ------------------------------------------------------------
    localparam int          DISABLE_WINDOW_CYC     = 4;
    localparam int          WIN_W                  = 3;

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int          IR_W                   = 4;
    localparam logic [3:0]  OP_EXTEST              = 4'h0;
    localparam logic [3:0]  OP_IDCODE              = 4'h1;
    localparam logic [3:0]  OP_SAMPLE_PRELOAD      = 4'h2;
    localparam logic [3:0]  OP_CORE_RESET          = 4'hC;
    localparam logic [3:0]  OP_BYPASS              = 4'hF;
    localparam logic [3:0]  IR_CAPTURE_VAL         = 4'h1;

    // ------------------------------------------------------------
    // Identification register layout
    // ------------------------------------------------------------
    localparam int          ID_W                   = 32;
    localparam int          ID_VER_W               = 4;
    localparam int          ID_PART_W              = 16;
    localparam int          ID_MFR_W               = 11;

    // Data path selected by the current instruction
    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_ID     = 2'h1,
        SEL_CHAIN  = 2'h2,
        SEL_RESET  = 2'h3
    } bst_sel_type;

    // TAP controller states
    typedef enum logic [15:0] {
        TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
        SHDR = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
        UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SHIR = 16'h0800,
        E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
    } bst_tap_type;

    // Four-wire test port, inputs side
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_tap_in_type;

endpackage : bst_pkg

// ===== design/bst_tap_datapath.sv
// Boundary-scan test access port with instruction decode, data paths,
// port-pin scan cells, reset observe cell and the AHB-Lite control registers.
// Assumes tck/tms/tdi and pins are asynchronous; core-side pin controls are on hclk.
//
// Overview of operation
// R1: Instruction register is four bits wide.
// R2: All shift registers move LSB first.
// R3: No HIGHZ; core reset tri-states pins.
// R4: Opcode 0 selects chain, drives pins immediately.
// R5: EXTEST captures pins, shifts, updates outputs.
// R6: Opcode 1 selects 32-bit ID; power-up default.
// R7: ID holds version, part, manufacturer; captured, shifted.
// R8: Opcode 2 samples pins, preloads latches, pins untouched.
// R9: Opcode 0xC selects reset bit; TAP unaffected.
// R10: Reset bit drives core reset directly, unlatched.
// R11: Opcode 0xF selects bypass; captures zero.
// R12: Disable bit off plus fuse enables port.
// R13: Software writes disable bit twice in four cycles.
// R14: Test reset flag sets on reset-bit reset.
// R15: Flag clears on power-on or written zero.
// R16: Pull-ups forced off under EXTEST or SAMPLE.
// R17: Each pin cell is two scan stages.
// R18: Cell takes raw pin, latch, direction bit; code captures the pin after two synchroniser flip-flops.
// R19: Pull-up equals latch, not direction, not disable.
// R20: Alternate functions outside cell; analog controls off.
// R21: No clock output under EXTEST or SAMPLE.
// R22: Reset pin observed by observe-only chain cell.
// R23: Version field four bits, revision-tracking.
// R24: Part field 16 bits, manufacturer 11 bits.
// R25: Unlisted opcodes select bypass register.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
module bst_tap_datapath
    import bst_pkg::*;
#(
    parameter int                 NUM_PINS  = 8,
    parameter logic [3:0]         VERSION   = 4'h0,
    parameter logic [15:0]        PART_NUM  = 16'h1234,  // Arbitrary value
    parameter logic [10:0]        MFR_ID    = 11'h055    // Arbitrary value
) (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Test port pins
    input  wire bst_tap_in_type       tap_in,
    output logic                      tdo_o,
    output logic                      tdo_oe,
    // Fuses and reset pin
    input  wire logic                 test_port_enable_fuse,
    input  wire logic                 clock_output_fuse,
    input  wire logic                 ext_reset_n,
    // Core side of the port pins
    input  wire logic [NUM_PINS-1:0]  direction_bit,
    input  wire logic [NUM_PINS-1:0]  output_latch_bit,
    input  wire logic                 core_clk_out,
    // Pads
    input  wire logic [NUM_PINS-1:0]  pad_in,
    output logic      [NUM_PINS-1:0]  pad_out,
    output logic      [NUM_PINS-1:0]  pad_oe,
    output logic      [NUM_PINS-1:0]  pullup_enable,
    output logic                      clk_out_pin,
    output logic                      analog_ctrl_off,
    // Core status
    output logic                      core_reset,
    output logic                      test_port_active,
    output logic                      global_pullup_disable
);

    localparam int CHAIN_LEN = 2 * NUM_PINS + 1;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic bst_sel_type decode_sel(input logic [IR_W-1:0] op);
        unique case (op)
            OP_EXTEST, OP_SAMPLE_PRELOAD: decode_sel = SEL_CHAIN;      // [R4] [R8]
            OP_IDCODE:                    decode_sel = SEL_ID;         // [R6]
            OP_CORE_RESET:                decode_sel = SEL_RESET;      // [R9]
            default:                      decode_sel = SEL_BYPASS;     // [R11] [R25]
        endcase
    endfunction : decode_sel

    function automatic bst_tap_type tap_next(input bst_tap_type s, input logic tms);
        unique case (s)
            TLR:  tap_next = tms ? TLR  : RTI;
            RTI:  tap_next = tms ? SDRS : RTI;
            SDRS: tap_next = tms ? SIRS : CDR;
            CDR:  tap_next = tms ? E1DR : SHDR;
            SHDR: tap_next = tms ? E1DR : SHDR;
            E1DR: tap_next = tms ? UDR  : PDR;
            PDR:  tap_next = tms ? E2DR : PDR;
            E2DR: tap_next = tms ? UDR  : SHDR;
            UDR:  tap_next = tms ? SDRS : RTI;
            SIRS: tap_next = tms ? TLR  : CIR;
            CIR:  tap_next = tms ? E1IR : SHIR;
            SHIR: tap_next = tms ? E1IR : SHIR;
            E1IR: tap_next = tms ? UIR  : PIR;
            PIR:  tap_next = tms ? E2IR : PIR;
            E2IR: tap_next = tms ? UIR  : SHIR;
            UIR:  tap_next = tms ? SDRS : RTI;
            default: tap_next = TLR;
        endcase
    endfunction : tap_next

    // ------------------------------------------------------------
    // Synchronisers for pins
    // ------------------------------------------------------------
    bst_tap_in_type        tap_s1_r, tap_s2_r;
    logic                  tck_prev_r;
    logic                  rstn_s1_r, rstn_s2_r;
    logic [NUM_PINS-1:0]   pad_s1_r, pad_s2_r;

    // Pads pass two flip-flops; this costs two hclk cycles of capture latency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tap_s1_r   <= '0;
            tap_s2_r   <= '0;
            tck_prev_r <= 1'b0;
            rstn_s1_r  <= 1'b1;
            rstn_s2_r  <= 1'b1;
            pad_s1_r   <= '0;
            pad_s2_r   <= '0;
        end else begin
            tap_s1_r   <= tap_in;
            tap_s2_r   <= tap_s1_r;
            tck_prev_r <= tap_s2_r.tck;
            rstn_s1_r  <= ext_reset_n;
            rstn_s2_r  <= rstn_s1_r;
            pad_s1_r   <= pad_in;
            pad_s2_r   <= pad_s1_r;
        end
    end

    logic tck_rise, tck_fall;
    assign tck_rise = tap_s2_r.tck & ~tck_prev_r;
    assign tck_fall = ~tap_s2_r.tck & tck_prev_r;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [REG_W-1:0]  mcu_control_r;
    logic [WIN_W-1:0]  arm_cnt_r;
    logic              test_reset_flag_r, arm_val_r, port_en, rst_reg_r;

    assign port_en               = test_port_enable_fuse & ~mcu_control_r[BIT_TEST_PORT_DISABLE];  // [R12]
    assign test_port_active      = port_en;
    assign global_pullup_disable = mcu_control_r[BIT_GLOBAL_PULLUP_DIS];

    // AHB-Lite address phase
    logic              dp_wr_r, ap_take;
    logic [31:0]       dp_addr_r;
    assign ap_take   = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= '0;
            hrdata    <= '0;
        end else begin
            dp_wr_r <= ap_take & hwrite;
            if (ap_take) begin
                dp_addr_r <= haddr;
            end
            if (ap_take && !hwrite) begin
                if (haddr == ADDR_MCU_CONTROL) begin
                    hrdata <= {24'h000000, mcu_control_r};
                end else if (haddr == ADDR_RESET_CAUSE) begin
                    hrdata <= {24'h000000, 3'b000, test_reset_flag_r, 4'h0};
                end else begin
                    hrdata <= '0;
                end
            end
        end
    end

    logic wr_ctl, wr_sta, new_dis;
    assign wr_ctl  = dp_wr_r & (dp_addr_r == ADDR_MCU_CONTROL);
    assign wr_sta  = dp_wr_r & (dp_addr_r == ADDR_RESET_CAUSE);
    assign new_dis = hwdata[BIT_TEST_PORT_DISABLE];

    // Disable bit changes only on a matching second write inside the window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mcu_control_r <= MCU_CONTROL_RST;
            arm_val_r     <= 1'b0;
            arm_cnt_r     <= '0;
        end else begin
            if (arm_cnt_r != '0) begin
                arm_cnt_r <= arm_cnt_r - 1'b1;
            end
            if (wr_ctl) begin
                mcu_control_r[BIT_TEST_PORT_DISABLE-1:0] <= hwdata[BIT_TEST_PORT_DISABLE-1:0];
                if (arm_cnt_r != '0 && arm_val_r == new_dis) begin
                    mcu_control_r[BIT_TEST_PORT_DISABLE] <= new_dis;  // [R13]
                    arm_cnt_r                            <= '0;
                end else begin
                    arm_val_r <= new_dis;
                    arm_cnt_r <= WIN_W'(DISABLE_WINDOW_CYC);  // [R13]
                end
            end
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_reset_flag_r <= 1'b0;  // [R15]
        end else if (rst_reg_r) begin
            test_reset_flag_r <= 1'b1;  // [R14]
        end else if (wr_sta && !hwdata[BIT_TEST_RESET_FLAG]) begin
            test_reset_flag_r <= 1'b0;  // [R15]
        end
    end

    // ------------------------------------------------------------
    // TAP controller
    // ------------------------------------------------------------
    bst_tap_type tap_r;

    // A disabled port holds the controller in Test-Logic-Reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tap_r <= TLR;
        end else if (!port_en) begin
            tap_r <= TLR;  // [R12]
        end else if (tck_rise) begin
            tap_r <= tap_next(tap_r, tap_s2_r.tms);
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [IR_W-1:0]  ir_sr_r;
    logic [IR_W-1:0]  ir_r;
    bst_sel_type      sel;
    logic             scan_mode, extest;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_sr_r <= '0;
            ir_r    <= OP_IDCODE;  // [R6]
        end else if (tap_r == TLR) begin
            ir_r    <= OP_IDCODE;  // [R6]
        end else if (tck_rise) begin
            unique case (tap_r)
                CIR:     ir_sr_r <= IR_CAPTURE_VAL;
                SHIR:    ir_sr_r <= {tap_s2_r.tdi, ir_sr_r[IR_W-1:1]};  // [R1] [R2]
                UIR:     ir_r    <= ir_sr_r;  // [R1]
                default: ir_sr_r <= ir_sr_r;
            endcase
        end
    end

    assign sel       = decode_sel(ir_r);
    assign extest    = (ir_r == OP_EXTEST);
    assign scan_mode = extest | (ir_r == OP_SAMPLE_PRELOAD);

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    logic                  byp_r;
    logic [ID_W-1:0]       id_sr_r;
    logic [CHAIN_LEN-1:0]  chain_r;
    logic [NUM_PINS-1:0]   upd_ctl_r, upd_dat_r;
    logic [ID_W-1:0]       id_val;
    logic [CHAIN_LEN-1:0]  chain_cap;
    logic                  do_cap, do_shift, do_upd;

    assign id_val   = {VERSION, PART_NUM, MFR_ID, 1'b1};  // [R7] [R23] [R24]
    assign do_cap   = tck_rise & (tap_r == CDR);
    assign do_shift = tck_rise & (tap_r == SHDR);
    assign do_upd   = tck_rise & (tap_r == UDR);

    // Even cell is drive control, odd cell is pin level, top cell observes reset pin
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            chain_cap[2*i]   = direction_bit[i];  // [R17] [R18]
            chain_cap[2*i+1] = pad_s2_r[i];  // [R5] [R8] [R18] [R20]
        end
        chain_cap[CHAIN_LEN-1] = rstn_s2_r;  // [R22]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byp_r <= 1'b0;
        end else if ((do_cap || do_shift) && sel == SEL_BYPASS) begin
            byp_r <= do_shift & tap_s2_r.tdi;  // [R11]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            id_sr_r <= '0;
        end else if (do_cap && sel == SEL_ID) begin
            id_sr_r <= id_val;  // [R7]
        end else if (do_shift && sel == SEL_ID) begin
            id_sr_r <= {tap_s2_r.tdi, id_sr_r[ID_W-1:1]};  // [R2] [R7]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_r <= '0;
        end else if (do_cap && sel == SEL_CHAIN) begin
            chain_r <= chain_cap;  // [R5] [R8]
        end else if (do_shift && sel == SEL_CHAIN) begin
            chain_r <= {tap_s2_r.tdi, chain_r[CHAIN_LEN-1:1]};  // [R2] [R5]
        end
    end

    // Update latches; the reset observe cell has none
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upd_ctl_r <= '0;
            upd_dat_r <= '0;
        end else if (do_upd && sel == SEL_CHAIN) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                upd_ctl_r[i] <= chain_r[2*i];  // [R5] [R8] [R17]
                upd_dat_r[i] <= chain_r[2*i+1];
            end
        end
    end

    // A power-on reset, Test-Logic-Reset or a shifted-in zero clears it; this instruction never resets the TAP
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_reg_r <= 1'b0;
        end else if (tap_r == TLR) begin
            rst_reg_r <= 1'b0;
        end else if (do_shift && sel == SEL_RESET) begin
            rst_reg_r <= tap_s2_r.tdi;  // [R9]
        end
    end

    assign core_reset = rst_reg_r | ~rstn_s2_r;  // [R10]

    // ------------------------------------------------------------
    // Test data out, changed on the falling edge of the test clock
    // ------------------------------------------------------------
    logic tdo_nxt;
    always_comb begin
        unique case (sel)
            SEL_ID:    tdo_nxt = id_sr_r[0];
            SEL_CHAIN: tdo_nxt = chain_r[0];
            SEL_RESET: tdo_nxt = rst_reg_r;
            default:   tdo_nxt = byp_r;
        endcase
        if (tap_r == SHIR) begin
            tdo_nxt = ir_sr_r[0];  // [R2]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdo_o  <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (!port_en) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_o  <= tdo_nxt;
            tdo_oe <= (tap_r == SHIR) | (tap_r == SHDR);
        end
    end

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    // EXTEST drives latches straight away; core reset otherwise tri-states the pads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out         <= '0;
            pad_oe          <= '0;
            pullup_enable   <= '0;
            clk_out_pin     <= 1'b0;
            analog_ctrl_off <= 1'b0;
        end else begin
            pad_out <= extest ? upd_dat_r : output_latch_bit;  // [R4] [R8] [R18]
            pad_oe  <= extest ? upd_ctl_r : (core_reset ? '0 : direction_bit);  // [R3] [R4] [R18]
            if (scan_mode) begin
                pullup_enable <= '0;  // [R16]
            end else begin
                pullup_enable <= output_latch_bit & ~direction_bit & {NUM_PINS{~global_pullup_disable}};  // [R19]
            end
            clk_out_pin     <= clock_output_fuse & ~scan_mode & core_clk_out;  // [R21]
            analog_ctrl_off <= scan_mode;  // [R20]
        end
    end

endmodule : bst_tap_datapath

// ===== verif/bst_checker.sv
// Checker of the scan datapath on the top-level ports.
// Assumes one hclk domain with async active-low hresetn.
module bst_checker
    import bst_pkg::*;
#(
    parameter int NUM_PINS = 8
) (
    // Clock, reset, bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    // Port and pads
    input wire logic tdo_oe,
    input wire logic test_port_enable_fuse,
    input wire logic [NUM_PINS-1:0] direction_bit,
    input wire logic [NUM_PINS-1:0] pad_oe,
    input wire logic [NUM_PINS-1:0] pullup_enable,
    input wire logic clk_out_pin,
    input wire logic analog_ctrl_off,
    input wire logic core_reset,
    input wire logic test_port_active,
    input wire logic global_pullup_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus stalled");
    property p_fuse; !test_port_enable_fuse |-> !test_port_active; endproperty
    a_fuse: assert property (p_fuse) else $error("port on, no fuse");
    property p_oe; !test_port_active ##1 !test_port_active |-> !tdo_oe; endproperty
    a_oe: assert property (p_oe) else $error("tdo driven");
    property p_pu_scan; analog_ctrl_off |-> pullup_enable == '0; endproperty
    a_pu_scan: assert property (p_pu_scan) else $error("pull-up in scan");
    property p_clk_scan; analog_ctrl_off |-> !clk_out_pin; endproperty
    a_clk_scan: assert property (p_clk_scan) else $error("clock out in scan");
    property p_pu_gpd; $past(global_pullup_disable) |-> pullup_enable == '0; endproperty
    a_pu_gpd: assert property (p_pu_gpd) else $error("pull-up not disabled");
    property p_pu_dir; (pullup_enable & $past(direction_bit)) == '0; endproperty
    a_pu_dir: assert property (p_pu_dir) else $error("pull-up on output");
    property p_tri; (core_reset && !analog_ctrl_off) [*2] |-> pad_oe == '0; endproperty
    a_tri: assert property (p_tri) else $error("pad driven in reset");
    c_scan: cover property (analog_ctrl_off);
    c_rst: cover property (core_reset);
    c_off: cover property (!test_port_active);
endmodule : bst_checker

// ===== verif/bst_jtag_host.sv
// Model of the external test controller on the four-wire port.
// Assumes hclk; the test clock stands low between bits.
module bst_jtag_host
    import bst_pkg::*;
(
    // Bench clock and test data out
    input wire logic clk,
    input wire logic tdo,
    // Test port pins
    output bst_tap_in_type tap
);
    timeunit 1ns;
    timeprecision 1ps;
    initial tap = '0;
    // Eight hclk high and nine hclk low per bit leave the synchroniser room
    task automatic step(input logic ms, input logic di, output logic q);
        @(posedge clk);
        tap.tms <= ms;
        tap.tdi <= di;
        repeat (8) @(posedge clk);
        q = tdo;
        tap.tck <= 1'b1;
        repeat (8) @(posedge clk);
        tap.tck <= 1'b0;
    endtask : step
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        repeat (int'(ir) + 1) step(1'b1, 1'b0, q);
        repeat (2) step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : bst_jtag_host

// ===== verif/bst_tap_datapath_test.sv
// Bench of the scan datapath: register access and test-port scans.
// Assumes bst_pkg, the design, the checker and the controller model.
module bst_tap_datapath_test
    import bst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 8;
    localparam logic [15:0] PRT = 16'h5A3C; // Arbitrary value
    localparam logic [10:0] MFR = 11'h2A6; // Arbitrary value
    logic hclk, hresetn, hwrite, hreadyout, hresp, tdo_o, tdo_oe, core_clk_out, clk_out_pin;
    logic test_port_enable_fuse, ext_reset_n, analog_ctrl_off, core_reset, test_port_active, global_pullup_disable;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, dout, din;
    logic [NP-1:0] direction_bit, output_latch_bit, pad_in, pad_out, pad_oe, pullup_enable;
    logic [3:0] ops [4] = '{OP_BYPASS, 4'h3, 4'h9, 4'hE};
    bst_tap_in_type tap;
    int bad_count, tests_run;
    bst_tap_datapath #(.NUM_PINS(NP), .VERSION(4'h0), .PART_NUM(PRT), .MFR_ID(MFR)) dut (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .tap_in(tap), .tdo_o, .tdo_oe, .test_port_enable_fuse,
        .clock_output_fuse(1'b1), .ext_reset_n, .direction_bit, .output_latch_bit, .core_clk_out, .pad_in,
        .pad_out, .pad_oe, .pullup_enable, .clk_out_pin, .analog_ctrl_off, .core_reset, .test_port_active,
        .global_pullup_disable);
    bst_jtag_host host (.clk(hclk), .tdo(tdo_o), .tap);
    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, seen, want);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic rdy;
        for (int n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
        @(posedge hclk);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
    endtask : rdy
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask : ahb
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd);
        ahb(1'b1, a, wd);
        ahb(1'b0, a, 32'h0);
    endtask : wr_rd
    function automatic logic [31:0] chain(input logic [NP-1:0] c, input logic [NP-1:0] v, input logic r);
        logic [31:0] x;
        x = '0;
        for (int i = 0; i < NP; i++) x[2*i+:2] = {v[i], c[i]};
        x[2*NP] = r;
        return x;
    endfunction : chain
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, direction_bit, output_latch_bit, pad_in, core_clk_out} = '0;
        {test_port_enable_fuse, ext_reset_n, bad_count, tests_run} = '0;
        test_port_enable_fuse = 1'b1;
        ext_reset_n = 1'b1;
        din = $urandom(32'hDC4C);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        host.step(1'b0, 1'b0, dout[0]);
        host.scan(1'b0, 32, din, dout);
        chk(dout, {4'h0, PRT, MFR, 1'b1}, "idcode");
        foreach (ops[k]) begin
            host.scan(1'b1, 4, 32'(ops[k]), dout);
            chk(dout, 32'(IR_CAPTURE_VAL), "ir capture");
            din = $urandom;
            host.scan(1'b0, 2, din, dout);
            chk(dout, {30'h0, din[0], 1'b0}, "bypass");
        end
        $display("bypass test done");
        direction_bit <= NP'($urandom);
        pad_in <= NP'($urandom);
        output_latch_bit <= NP'($urandom);
        core_clk_out <= 1'b1;
        host.scan(1'b1, 4, 32'(OP_SAMPLE_PRELOAD), dout);
        din = $urandom & ((32'h1 << 2 * NP) - 32'h1);
        host.scan(1'b0, 2 * NP + 1, din, dout);
        chk(dout, chain(direction_bit, pad_in, 1'b1), "sample");
        chk(32'(pad_oe), 32'(direction_bit), "pins kept");
        host.scan(1'b1, 4, 32'(OP_EXTEST), dout);
        chk(chain(pad_oe, pad_out, 1'b0), din, "extest drive");
        ext_reset_n <= 1'b0;
        din = $urandom & ((32'h1 << 2 * NP) - 32'h1);
        host.scan(1'b0, 2 * NP + 1, din, dout);
        chk(dout & chain('0, '1, 1'b1), chain('0, pad_in, 1'b0), "extest capture");
        chk(chain(pad_oe, pad_out, 1'b0), din, "extest update");
        ext_reset_n <= 1'b1;
        $display("boundary test done");
        host.scan(1'b1, 4, 32'(OP_CORE_RESET), dout);
        host.scan(1'b0, 1, 32'h1, dout);
        chk(32'(core_reset), 32'h1, "reset held");
        wr_rd(ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h10, "flag set");
        host.scan(1'b0, 1, 32'h0, dout);
        chk(dout, 32'h1, "reset bit kept");
        chk(32'(core_reset), 32'h0, "reset freed");
        wr_rd(ADDR_RESET_CAUSE, 32'h10);
        chk(rd, 32'h10, "flag kept");
        wr_rd(ADDR_RESET_CAUSE, 32'h0);
        chk(rd, 32'h0, "flag cleared");
        $display("reset test done");
        wr_rd(ADDR_MCU_CONTROL, 32'h90);
        chk(rd, 32'h10, "single write");
        ahb(1'b1, ADDR_MCU_CONTROL, 32'h80);
        wr_rd(ADDR_MCU_CONTROL, 32'h80);
        chk(rd, 32'h80, "timed write");
        chk(32'(test_port_active), 32'h0, "port off");
        host.scan(1'b0, 32, din, dout);
        ahb(1'b1, ADDR_MCU_CONTROL, 32'h0);
        wr_rd(ADDR_MCU_CONTROL, 32'h0);
        chk(32'(test_port_active), 32'h1, "port on");
        wr_rd(32'h8, 32'hFF);
        chk(rd, 32'h0, "unmapped");
        test_port_enable_fuse <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(32'(test_port_active), 32'h0, "fuse off");
        $display("control test done");
        end_of_test();
    end
endmodule : bst_tap_datapath_test
bind bst_tap_datapath bst_checker #(.NUM_PINS(NUM_PINS)) chk_i (.*);
